// ==== rfg_pkg.sv ====
// shared constants for the resistance-to-frequency gated counter
package rfg_pkg;
	localparam logic [31:0] ADDR_OSC_CFG = 32'h0000_00af * 32'h4;
	localparam logic [31:0] ADDR_CLK_CFG = 32'h0000_00d8 * 32'h4;
	localparam logic [31:0] ADDR_AUXILIARY_CONTROL_ONE = 32'h0000_00f8 * 32'h4;
	localparam logic [7:0] OSC_CFG_RESET = 8'h0c;
	localparam logic [7:0] CLK_CFG_RESET = 8'h05;
	localparam logic [7:0] AUXILIARY_CONTROL_ONE_RESET = 8'h00;
	localparam logic [7:0] AUXILIARY_CONTROL_ONE_MASK = 8'h1f;
	localparam int PIN_MODE_LSB = 6;
	localparam int CNT_SEL_LSB = 4;
	localparam int PSC_LSB = 2;
	localparam int CHAN_LSB = 0;
	localparam int OSC_STOP_BIT = 1;
	localparam int FCK_TYPE_BIT = 7;
	localparam int FCK_SEL_BIT = 5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] SEL_PIN = 2'h0;
	localparam logic [1:0] SEL_OSC = 2'h1;
	localparam logic [1:0] SEL_XTAL = 2'h2;
	localparam logic [1:0] SEL_GATED = 2'h3;
	localparam int PSC_W = 6;
	typedef enum logic [1:0] {RFG_G_IDLE, RFG_G_ARMED, RFG_G_OPEN, RFG_G_DONE} rfg_gate_t;
endpackage : rfg_pkg

// ==== rfg_sync.sv ====
// two-flop synchroniser for one level
`timescale 1ns/1ps
module rfg_sync (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic d_in,
	output logic q_out
);
	typedef struct packed {logic s1; logic s2;} rfg_sync_t;
	rfg_sync_t st_r, st_nxt;
	always_comb begin
		st_nxt.s1 = d_in;
		st_nxt.s2 = st_r.s1;
	end
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign q_out = st_r.s2;
endmodule // rfg_sync

// ==== rfg_prescaler.sv ====
// oscillator edge prescaler, divide by 64/16/4/1
`timescale 1ns/1ps
module rfg_prescaler
	import rfg_pkg::*;
#(
	parameter int W = PSC_W
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic edge_in,
	input wire logic [1:0] psc_in,
	output logic tick_out
);
	typedef struct packed {logic [W-1:0] cnt; logic tick;} rfg_psc_t;
	rfg_psc_t st_r, st_nxt;
	logic [W-1:0] last;
	always_comb begin
		unique case (psc_in)
			2'h0: last = W'(63);
			2'h1: last = W'(15);
			2'h2: last = W'(3);
			default: last = '0;
		endcase
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (edge_in) begin
			if (st_r.cnt >= last) begin
				st_nxt.cnt = '0;
				st_nxt.tick = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 1'b1;
			end
		end
	end
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign tick_out = st_r.tick;
endmodule // rfg_prescaler

// ==== rfg_core.sv ====
// converter control: register slave, pin routing, prescale and timer-2 gating
//
// Behaviour
// - channel field picks one reference pin: 00 first, 01 second, 10 third.
// - at most one oscillation circuit is ever enabled at once.
// - pin mode field gives converter 0, 2, 3 or 4 port-0 pins.
// - count input select picks pin, divided osc, slow crystal or gated osc.
// - prescaler divides oscillator by 64, 16, 4 or 1.
// - select 3 passes divided osc only between timer-2 overflows.
// - stop bit halts oscillator and clears gate, waiting for next overflow.
// - after stop cleared, count only between next two overflows, then stop.
// - fast clock type changes only when fast clock select is 0.
// - fast clock type 1 picks converter oscillator as fast clock.
// - segment pin mode overrides converter pin mode on shared pins.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module rfg_core
	import rfg_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic osc_clk_in,
	input wire logic t2_overflow_in,
	input wire logic count_pin_in,
	input wire logic slow_crystal_in,
	input wire logic timer0_counter_mode_in,
	input wire logic [3:0] segment_pin_mode_in,
	output logic [3:0] converter_pin_mode_out,
	output logic [2:0] ref_resistor_en_out,
	output logic osc_run_out,
	output logic t0_count_out,
	output logic fast_clock_type_out,
	output logic gate_open_out
);
	typedef struct packed {
		logic [7:0] osc_cfg;
		logic [7:0] clk_cfg;
		logic [7:0] auxiliary_control_one;
		logic aw_got;
		logic w_got;
		logic [31:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic osc_d;
		logic ovf_d;
		logic xtal_d;
		logic pin_d;
		rfg_gate_t gate;
		logic t0_cnt;
		logic [3:0] pins;
		logic [2:0] ref_en;
	} rfg_state_t;

	rfg_state_t st_r, st_nxt;
	logic osc_s, ovf_s, xtal_s, pin_s;
	logic osc_edge, ovf_pulse, xtal_edge, pin_fall, psc_tick;

	function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [31:0] d, input logic [3:0] be);
		merge_byte = be[0] ? d[7:0] : old_v;
	endfunction

	function automatic logic [3:0] pins_of_mode(input logic [1:0] m);
		unique case (m)
			2'h0: pins_of_mode = 4'h0;
			2'h1: pins_of_mode = 4'h3;
			2'h2: pins_of_mode = 4'h7;
			default: pins_of_mode = 4'hf;
		endcase
	endfunction

	rfg_sync u_sync_osc (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .d_in(osc_clk_in), .q_out(osc_s));
	rfg_sync u_sync_ovf (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .d_in(t2_overflow_in), .q_out(ovf_s));
	rfg_sync u_sync_xtal (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .d_in(slow_crystal_in), .q_out(xtal_s));
	rfg_sync u_sync_pin (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .d_in(count_pin_in), .q_out(pin_s));

	assign osc_edge = osc_s & ~st_r.osc_d & ~st_r.auxiliary_control_one[OSC_STOP_BIT];
	assign ovf_pulse = ovf_s & ~st_r.ovf_d;
	assign xtal_edge = xtal_s & ~st_r.xtal_d;
	assign pin_fall = ~pin_s & st_r.pin_d;

	rfg_prescaler u_psc (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.edge_in(osc_edge),
		.psc_in(st_r.osc_cfg[PSC_LSB +: 2]),
		.tick_out(psc_tick)
	);

	always_comb begin
		logic wr_fire;
		logic [1:0] sel;
		logic [3:0] conv_pins;
		st_nxt = st_r;
		wr_fire = 1'b0;
		conv_pins = 4'h0;
		sel = st_r.osc_cfg[CNT_SEL_LSB +: 2];
		st_nxt.osc_d = osc_s;
		st_nxt.ovf_d = ovf_s;
		st_nxt.xtal_d = xtal_s;
		st_nxt.pin_d = pin_s;

		// write channel: address and data taken in either order
		if (s_axi_awvalid && !st_r.aw_got) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_r.w_got) begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
		end
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
			wr_fire = 1'b1;
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			unique case (st_r.awaddr)
				ADDR_OSC_CFG: st_nxt.osc_cfg = merge_byte(st_r.osc_cfg, st_r.wdata, st_r.wstrb);
				ADDR_CLK_CFG: begin
					st_nxt.clk_cfg = merge_byte(st_r.clk_cfg, st_r.wdata, st_r.wstrb);
					if (st_r.clk_cfg[FCK_SEL_BIT]) begin
						st_nxt.clk_cfg[FCK_TYPE_BIT] = st_r.clk_cfg[FCK_TYPE_BIT];
					end
				end
				ADDR_AUXILIARY_CONTROL_ONE: st_nxt.auxiliary_control_one = merge_byte(st_r.auxiliary_control_one, st_r.wdata, st_r.wstrb) & AUXILIARY_CONTROL_ONE_MASK;
				default: st_nxt.bresp = RESP_SLVERR;
			endcase
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end

		// read channel
		if (s_axi_arvalid && !st_r.rvalid) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_OSC_CFG: st_nxt.rdata = {24'h000000, st_r.osc_cfg};
				ADDR_CLK_CFG: st_nxt.rdata = {24'h000000, st_r.clk_cfg};
				ADDR_AUXILIARY_CONTROL_ONE: st_nxt.rdata = {24'h000000, st_r.auxiliary_control_one};
				default: begin
					st_nxt.rdata = 32'h0000_0000;
					st_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end else if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end

		// gate sequencer for timer-2 windowed counting
		if (st_r.auxiliary_control_one[OSC_STOP_BIT] || sel != SEL_GATED) begin
			st_nxt.gate = RFG_G_IDLE;
		end else begin
			unique case (st_r.gate)
				RFG_G_IDLE: st_nxt.gate = RFG_G_ARMED;
				RFG_G_ARMED: if (ovf_pulse) st_nxt.gate = RFG_G_OPEN;
				RFG_G_OPEN: if (ovf_pulse) st_nxt.gate = RFG_G_DONE;
				RFG_G_DONE: st_nxt.gate = RFG_G_DONE;
			endcase
		end

		// timer-0 count source, one-cycle pulse per counted event
		st_nxt.t0_cnt = 1'b0;
		if (timer0_counter_mode_in) begin
			unique case (sel)
				SEL_PIN: st_nxt.t0_cnt = pin_fall;
				SEL_OSC: st_nxt.t0_cnt = psc_tick;
				SEL_XTAL: st_nxt.t0_cnt = xtal_edge;
				SEL_GATED: st_nxt.t0_cnt = psc_tick && st_r.gate == RFG_G_OPEN;
			endcase
		end

		// pin ownership and single reference resistor
		conv_pins = pins_of_mode(st_r.osc_cfg[PIN_MODE_LSB +: 2]);
		st_nxt.pins = conv_pins & ~segment_pin_mode_in;
		st_nxt.ref_en = 3'h0;
		if (!st_r.auxiliary_control_one[OSC_STOP_BIT] && st_nxt.pins[0]) begin
			unique case (st_r.osc_cfg[CHAN_LSB +: 2])
				2'h0: st_nxt.ref_en = {2'h0, st_nxt.pins[1]};
				2'h1: st_nxt.ref_en = {1'b0, st_nxt.pins[2], 1'b0};
				2'h2: st_nxt.ref_en = {st_nxt.pins[3], 2'h0};
				default: st_nxt.ref_en = 3'h0;
			endcase
		end
		if (wr_fire) begin
			st_nxt.ref_en = 3'h0;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= '0;
			st_r.osc_cfg <= OSC_CFG_RESET;
			st_r.clk_cfg <= CLK_CFG_RESET;
			st_r.auxiliary_control_one <= AUXILIARY_CONTROL_ONE_RESET;
			st_r.gate <= RFG_G_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s_axi_awready = !st_r.aw_got;
	assign s_axi_wready = !st_r.w_got;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign converter_pin_mode_out = st_r.pins;
	assign ref_resistor_en_out = st_r.ref_en;
	assign osc_run_out = |st_r.ref_en;
	assign t0_count_out = st_r.t0_cnt;
	assign fast_clock_type_out = st_r.clk_cfg[FCK_TYPE_BIT];
	assign gate_open_out = st_r.gate == RFG_G_OPEN;
endmodule // rfg_core

// ==== rfg_rc_net.sv ====
// behavioural rc network, oscillates only while a reference pin is on
`timescale 1ns/1ps
module rfg_rc_net (
	input wire logic run_in,
	output logic osc_clk_out
);
	initial osc_clk_out = 1'b0;
	always #40 osc_clk_out = run_in ? ~osc_clk_out : 1'b0;
endmodule // rfg_rc_net

// ==== rfg_chk.sv ====
// port assertions for the converter control
`timescale 1ns/1ps
module rfg_chk (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic timer0_counter_mode_in,
	input wire logic [3:0] segment_pin_mode_in,
	input wire logic [3:0] converter_pin_mode_out,
	input wire logic [2:0] ref_resistor_en_out,
	input wire logic osc_run_out,
	input wire logic t0_count_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	one_osc_a: assert property ($onehot0(ref_resistor_en_out)) else $error("two refs on");
	run_flag_a: assert property (osc_run_out == |ref_resistor_en_out) else $error("run flag wrong");
	ref_owned_a: assert property (|ref_resistor_en_out |-> converter_pin_mode_out[0]
		&& (ref_resistor_en_out & ~converter_pin_mode_out[3:1]) == 3'h0) else $error("ref pin not owned");
	seg_wins_a: assert property (
		(converter_pin_mode_out & segment_pin_mode_in & $past(segment_pin_mode_in)) == 4'h0)
		else $error("segment pin taken");
	mode_off_a: assert property ((!timer0_counter_mode_in) [*4] |-> !t0_count_out) else $error("count in mode off");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	r_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
endmodule // rfg_chk
bind rfg_core rfg_chk u_chk (.*);

// ==== res_to_freq_gated_counter_tb_top.sv ====
// self-checking bench for the converter control
`timescale 1ns/1ps
module res_to_freq_gated_counter_tb_top;
	import rfg_pkg::*;
	logic clk_sys_in, rst_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, osc_clk_in, t2_overflow_in, count_pin_in;
	logic slow_crystal_in, timer0_counter_mode_in, osc_run_out, t0_count_out, fast_clock_type_out, gate_open_out;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb, segment_pin_mode_in, converter_pin_mode_out;
	logic [2:0] ref_resistor_en_out;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int err_total, checks, cnt, cyc;
	rfg_core dut (.*);
	rfg_rc_net u_net (.run_in(osc_run_out), .osc_clk_out(osc_clk_in));
	initial begin
		clk_sys_in = 0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		{count_pin_in, slow_crystal_in} <= {2{cyc[3]}};
		if (t0_count_out === 1'b1) cnt <= cnt + 1;
		if (cyc == 40000) begin
			err_total++;
			final_report();
		end
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
		bit ad = 0, wd = 0;
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
		while (!(ad && wd)) begin
			@(posedge clk_sys_in);
			ad |= s_axi_awready;
			wd |= s_axi_wready;
			if (ad) s_axi_awvalid <= 0;
			if (wd) s_axi_wvalid <= 0;
		end
		s_axi_bready <= 1;
		do @(posedge clk_sys_in); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask
	task automatic rd(input logic [31:0] a, e, input logic [1:0] er);
		{s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
		do @(posedge clk_sys_in); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		s_axi_rready <= 1;
		do @(posedge clk_sys_in); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask
	task automatic cc(input int n, e);
		int c0 = cnt;
		w(n);
		checks++;
		if (cnt - c0 > e + 1 || cnt - c0 < e - 1) begin
			err_total++;
			$display("mismatch count expected %0d seen %0d", e, cnt - c0);
		end
	endtask
	task automatic ovf;
		t2_overflow_in <= 1;
		w(4);
		t2_overflow_in <= 0;
		w(4);
	endtask
	initial begin
		{rst_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, t2_overflow_in, count_pin_in, slow_crystal_in} = '0;
		{err_total, checks, cnt, cyc} = '0;
		{s_axi_wstrb, segment_pin_mode_in, timer0_counter_mode_in} = 9'h1e1;
		w(8);
		rst_in <= 0;
		rd(ADDR_OSC_CFG, {24'h0, OSC_CFG_RESET}, RESP_OKAY);
		rd(ADDR_CLK_CFG, {24'h0, CLK_CFG_RESET}, RESP_OKAY);
		rd(ADDR_AUXILIARY_CONTROL_ONE, {24'h0, AUXILIARY_CONTROL_ONE_RESET}, RESP_OKAY);
		rd(32'h10, 32'h0, RESP_SLVERR);
		wr(32'h10, 32'hff, RESP_SLVERR);
		wr(ADDR_AUXILIARY_CONTROL_ONE, 32'hff, RESP_OKAY);
		rd(ADDR_AUXILIARY_CONTROL_ONE, {24'h0, AUXILIARY_CONTROL_ONE_MASK}, RESP_OKAY);
		wr(ADDR_AUXILIARY_CONTROL_ONE, 32'h0, RESP_OKAY);
		wr(ADDR_CLK_CFG, 32'h85, RESP_OKAY);
		chk("fck", 32'h1, {31'h0, fast_clock_type_out});
		wr(ADDR_CLK_CFG, 32'ha5, RESP_OKAY);
		wr(ADDR_CLK_CFG, 32'h25, RESP_OKAY);
		rd(ADDR_CLK_CFG, 32'ha5, RESP_OKAY);
		wr(ADDR_CLK_CFG, 32'h05, RESP_OKAY);
		wr(ADDR_CLK_CFG, 32'h05, RESP_OKAY);
		chk("fck", 32'h0, {31'h0, fast_clock_type_out});
		$display("register test done");
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_OSC_CFG, {24'h0, m[1:0], 6'h0}, RESP_OKAY);
			w(4);
			chk("pins", {28'h0, m == 3, m > 1, m > 0, m > 0}, {28'h0, converter_pin_mode_out});
		end
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_OSC_CFG, {24'h0, 6'h30, c[1:0]}, RESP_OKAY);
			w(4);
			chk("ref", 32'(c < 3) << c, {29'h0, ref_resistor_en_out});
		end
		segment_pin_mode_in <= 4'h2;
		wr(ADDR_OSC_CFG, 32'hc0, RESP_OKAY);
		w(4);
		chk("pins", 32'hd, {28'h0, converter_pin_mode_out});
		chk("ref", 32'h0, {29'h0, ref_resistor_en_out});
		segment_pin_mode_in <= 4'h0;
		$display("pin test done");
		for (int s = 0; s < 3; s++) begin
			wr(ADDR_OSC_CFG, {24'h0, 2'h3, s[1:0], 4'hc}, RESP_OKAY);
			cc(2048, 128);
		end
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_OSC_CFG, {24'h0, 4'hd, p[1:0], 2'h0}, RESP_OKAY);
			cc(2048, 128 >> (6 - 2 * p));
		end
		timer0_counter_mode_in <= 0;
		cc(512, 0);
		timer0_counter_mode_in <= 1;
		$display("count test done");
		wr(ADDR_OSC_CFG, 32'hfc, RESP_OKAY);
		wr(ADDR_AUXILIARY_CONTROL_ONE, 32'h2, RESP_OKAY);
		wr(ADDR_AUXILIARY_CONTROL_ONE, 32'h0, RESP_OKAY);
		cc(200, 0);
		ovf();
		cc(800, 50);
		ovf();
		w(8);
		cc(400, 0);
		wr(ADDR_AUXILIARY_CONTROL_ONE, 32'h2, RESP_OKAY);
		ovf();
		chk("gate", 32'h0, {31'h0, gate_open_out});
		wr(ADDR_AUXILIARY_CONTROL_ONE, 32'h0, RESP_OKAY);
		ovf();
		chk("gate", 32'h1, {31'h0, gate_open_out});
		wr(ADDR_AUXILIARY_CONTROL_ONE, 32'h2, RESP_OKAY);
		// the stop bit lands one edge before the gate register sees it
		w(1);
		chk("gate", 32'h0, {31'h0, gate_open_out});
		$display("gate test done");
		final_report();
	end
endmodule // res_to_freq_gated_counter_tb_top
